/* File: logic/fblse_pkg.sv */
package fblse_pkg;
    // datapath widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int REG_COUNT = 32;
    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // low register of each pointer pair
    localparam logic [4:0] PTR_X_LO = 5'h1a;
    localparam logic [4:0] PTR_Y_LO = 5'h1c;
    localparam logic [4:0] PTR_Z_LO = 5'h1e;
    // pointer pair choice
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} fblse_ptr_t;
    // pointer addressing mode
    typedef enum logic [1:0] {PM_PLAIN, PM_POST_INC, PM_PRE_DEC} fblse_mode_t;
    // decoded operations
    typedef enum logic [4:0] {
        nop_op, flag_force_one_op, flag_force_zero_op,
        bit_to_transfer_flag_op, transfer_flag_to_bit_op,
        overflow_force_one_op, overflow_force_zero_op,
        half_carry_force_one_op, half_carry_force_zero_op,
        signed_test_force_one_op, signed_test_force_zero_op,
        move_op, register_pair_copy_op, immediate_load_op, nibble_swap_op,
        pointer_load_op, displaced_load_op, direct_load_op,
        pointer_store_op, displaced_store_op
    } fblse_op_t;
    // one decoded instruction
    typedef struct packed {
        fblse_op_t op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [2:0] bitSel;
        logic [7:0] imm;
        fblse_ptr_t ptr;
        fblse_mode_t mode;
        logic [5:0] disp;
        logic [15:0] addr;
    } fblse_inst_t;
    // data memory request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic read;
        logic write;
    } fblse_mem_t;
endpackage : fblse_pkg

/* File: logic/fblse_exec.sv */
// Behaviour
// - bit store copies register bit to transfer flag
// - bit load writes transfer flag into register
// - overflow flag forced one or zero alone
// - half carry flag forced one or zero
// - signed test flag forced one or zero
// - post increment load reads then bumps pointer
// - pre decrement load drops pointer then reads
// - displaced load reads pointer plus offset
// - direct load reads address from instruction
// - post increment store writes then bumps pointer
// - pre decrement store drops pointer then writes
// - displaced store writes pointer plus offset
`timescale 1ns/10ps
module fblse_exec (
    input wire logic clock,
    input wire logic resetn,
    input wire logic instValid,
    input wire fblse_pkg::fblse_inst_t inst,
    output logic instReady,
    output logic instDone,
    output fblse_pkg::fblse_mem_t memReq,
    input wire logic [7:0] memRdata,
    output logic [7:0] flags,
    input wire logic [4:0] dbgSel,
    output logic [7:0] dbgData
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic {IDLE, MEM_PHASE} fblse_state_t;
    fblse_state_t state_reg, state_next; // sequencer
    logic [7:0] rf_reg [fblse_pkg::REG_COUNT]; // working registers
    logic [7:0] rf_next [fblse_pkg::REG_COUNT];
    logic [7:0] flags_reg, flags_next; // status flag register
    fblse_pkg::fblse_mem_t mem_reg, mem_next; // memory request
    logic done_reg, done_next; // completion pulse
    logic pendLoad_reg, pendLoad_next; // load waits for data
    logic [4:0] pendDest_reg, pendDest_next; // load destination
    logic [7:0] dbg_reg, dbg_next; // register peek
    logic [4:0] ptrLo; // low register of chosen pair
    logic [15:0] ptrVal; // chosen pointer value
    logic [15:0] ptrUpd; // pointer after step
    logic [15:0] effAddr; // effective data address
    logic [4:0] pairD, pairR; // even pair indices
    logic accept; // instruction taken this cycle

    ////////////////////////////////////////////////////////////////////
    // pointer selection and address arithmetic
    always_comb begin
        case (inst.ptr)
            fblse_pkg::PTR_X: ptrLo = fblse_pkg::PTR_X_LO;
            fblse_pkg::PTR_Y: ptrLo = fblse_pkg::PTR_Y_LO;
            default: ptrLo = fblse_pkg::PTR_Z_LO;
        endcase
        ptrVal = {rf_reg[ptrLo + 5'h01], rf_reg[ptrLo]};
        // step up after access or down before it
        if (inst.mode == fblse_pkg::PM_POST_INC) begin
            ptrUpd = ptrVal + 16'h0001;
        end else begin
            ptrUpd = ptrVal - 16'h0001;
        end
        case (inst.op)
            fblse_pkg::direct_load_op: effAddr = inst.addr;
            fblse_pkg::displaced_load_op,
            fblse_pkg::displaced_store_op: begin
                effAddr = ptrVal + {10'h000, inst.disp};
            end
            default: begin
                // pre decrement uses the new value, others the old one
                if (inst.mode == fblse_pkg::PM_PRE_DEC) begin
                    effAddr = ptrUpd;
                end else begin
                    effAddr = ptrVal;
                end
            end
        endcase
        pairD = {inst.rd[4:1], 1'b0};
        pairR = {inst.rr[4:1], 1'b0};
    end

    assign instReady = (state_reg == IDLE);
    assign accept = instValid && instReady;

    ////////////////////////////////////////////////////////////////////
    // next state of sequencer, registers, flags and memory request
    always_comb begin
        state_next = state_reg;
        rf_next = rf_reg;
        flags_next = flags_reg;
        mem_next = '0;
        done_next = 1'b0;
        pendLoad_next = 1'b0;
        pendDest_next = pendDest_reg;
        dbg_next = rf_reg[dbgSel];
        case (state_reg)
            IDLE: begin
                if (accept) begin
                    done_next = 1'b1; // one cycle ops finish here
                    case (inst.op)
                        fblse_pkg::flag_force_one_op: begin
                            flags_next[inst.bitSel] = 1'b1;
                        end
                        fblse_pkg::flag_force_zero_op: begin
                            flags_next[inst.bitSel] = 1'b0;
                        end
                        fblse_pkg::bit_to_transfer_flag_op: begin
                            flags_next[fblse_pkg::FLAG_T] =
                                rf_reg[inst.rr][inst.bitSel];
                        end
                        fblse_pkg::transfer_flag_to_bit_op: begin
                            rf_next[inst.rd][inst.bitSel] =
                                flags_reg[fblse_pkg::FLAG_T];
                        end
                        fblse_pkg::overflow_force_one_op: begin
                            flags_next[fblse_pkg::FLAG_V] = 1'b1;
                        end
                        fblse_pkg::overflow_force_zero_op: begin
                            flags_next[fblse_pkg::FLAG_V] = 1'b0;
                        end
                        fblse_pkg::half_carry_force_one_op: begin
                            flags_next[fblse_pkg::FLAG_H] = 1'b1;
                        end
                        fblse_pkg::half_carry_force_zero_op: begin
                            flags_next[fblse_pkg::FLAG_H] = 1'b0;
                        end
                        fblse_pkg::signed_test_force_one_op: begin
                            flags_next[fblse_pkg::FLAG_S] = 1'b1;
                        end
                        fblse_pkg::signed_test_force_zero_op: begin
                            flags_next[fblse_pkg::FLAG_S] = 1'b0;
                        end
                        fblse_pkg::move_op: begin
                            rf_next[inst.rd] = rf_reg[inst.rr];
                        end
                        fblse_pkg::register_pair_copy_op: begin
                            rf_next[pairD] = rf_reg[pairR];
                            rf_next[pairD + 5'h01] = rf_reg[pairR + 5'h01];
                        end
                        fblse_pkg::immediate_load_op: begin
                            rf_next[inst.rd] = inst.imm;
                        end
                        fblse_pkg::nibble_swap_op: begin
                            rf_next[inst.rd] = {rf_reg[inst.rd][3:0],
                                rf_reg[inst.rd][7:4]};
                        end
                        fblse_pkg::pointer_load_op,
                        fblse_pkg::displaced_load_op,
                        fblse_pkg::direct_load_op,
                        fblse_pkg::pointer_store_op,
                        fblse_pkg::displaced_store_op: begin
                            // two cycle transfers: issue now, end later
                            done_next = 1'b0;
                            state_next = MEM_PHASE;
                            mem_next.addr = effAddr;
                            mem_next.wdata = rf_reg[inst.rr];
                            mem_next.write =
                                (inst.op == fblse_pkg::pointer_store_op) ||
                                (inst.op == fblse_pkg::displaced_store_op);
                            mem_next.read = !mem_next.write;
                            pendLoad_next = !mem_next.write;
                            pendDest_next = inst.rd;
                            // only pointer load and store in post increment or pre decrement mode step the pointer
                            if ((inst.op == fblse_pkg::pointer_load_op ||
                                 inst.op == fblse_pkg::pointer_store_op) &&
                                inst.mode != fblse_pkg::PM_PLAIN) begin
                                rf_next[ptrLo] = ptrUpd[7:0];
                                rf_next[ptrLo + 5'h01] = ptrUpd[15:8];
                            end
                        end
                        default: begin
                            // no operation
                        end
                    endcase
                end
            end
            MEM_PHASE: begin
                // second cycle: capture load data, finish
                if (pendLoad_reg) begin
                    rf_next[pendDest_reg] = memRdata;
                end
                done_next = 1'b1;
                state_next = IDLE;
            end
            default: state_next = IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= IDLE;
            for (int i = 0; i < fblse_pkg::REG_COUNT; i++) begin
                rf_reg[i] <= fblse_pkg::REG_RESET;
            end
            flags_reg <= fblse_pkg::FLAGS_RESET;
            mem_reg <= '0;
            done_reg <= 1'b0;
            pendLoad_reg <= 1'b0;
            pendDest_reg <= 5'h00;
            dbg_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            rf_reg <= rf_next;
            flags_reg <= flags_next;
            mem_reg <= mem_next;
            done_reg <= done_next;
            pendLoad_reg <= pendLoad_next;
            pendDest_reg <= pendDest_next;
            dbg_reg <= dbg_next;
        end
    end

    assign instDone = done_reg;
    assign memReq = mem_reg;
    assign flags = flags_reg;
    assign dbgData = dbg_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    localparam logic [7:0] T_MASK = 8'h01 << fblse_pkg::FLAG_T;
    localparam logic [7:0] V_MASK = 8'h01 << fblse_pkg::FLAG_V;
    localparam logic [7:0] H_MASK = 8'h01 << fblse_pkg::FLAG_H;
    localparam logic [7:0] S_MASK = 8'h01 << fblse_pkg::FLAG_S;
    logic isMem; // accepted op is a memory transfer
    assign isMem = accept && inst.op >= fblse_pkg::pointer_load_op &&
        inst.op <= fblse_pkg::displaced_store_op;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_bit_to_flag: assert property (
        accept && inst.op == fblse_pkg::bit_to_transfer_flag_op |=>
        flags_reg[fblse_pkg::FLAG_T] == $past(rf_reg[inst.rr][inst.bitSel])
        && (flags_reg & ~T_MASK) == ($past(flags_reg) & ~T_MASK) && instDone)
        else $error("bit store did not copy into transfer flag");
    a_flag_to_bit: assert property (
        accept && inst.op == fblse_pkg::transfer_flag_to_bit_op |=>
        rf_reg[$past(inst.rd)][$past(inst.bitSel)] ==
        $past(flags_reg[fblse_pkg::FLAG_T]) && flags_reg == $past(flags_reg))
        else $error("bit load did not write transfer flag");
    a_ovf_force: assert property (
        accept && inst.op == fblse_pkg::overflow_force_one_op |=>
        flags_reg[fblse_pkg::FLAG_V] &&
        (flags_reg & ~V_MASK) == ($past(flags_reg) & ~V_MASK))
        else $error("overflow force one wrong");
    a_half_force: assert property (
        accept && inst.op == fblse_pkg::half_carry_force_zero_op |=>
        !flags_reg[fblse_pkg::FLAG_H] &&
        (flags_reg & ~H_MASK) == ($past(flags_reg) & ~H_MASK))
        else $error("half carry force zero wrong");
    a_sign_force: assert property (
        accept && inst.op == fblse_pkg::signed_test_force_one_op |=>
        flags_reg[fblse_pkg::FLAG_S] &&
        (flags_reg & ~S_MASK) == ($past(flags_reg) & ~S_MASK))
        else $error("signed test force one wrong");
    a_postinc_ptr: assert property (
        isMem && inst.op == fblse_pkg::pointer_load_op &&
        inst.mode == fblse_pkg::PM_POST_INC |=> memReq.read &&
        memReq.addr == $past(ptrVal) &&
        {rf_reg[$past(ptrLo) + 5'h01], rf_reg[$past(ptrLo)]} ==
        $past(ptrVal) + 16'h0001)
        else $error("post increment load address or pointer wrong");
    a_predec_addr: assert property (
        isMem && inst.op == fblse_pkg::pointer_store_op &&
        inst.mode == fblse_pkg::PM_PRE_DEC |=> memReq.write &&
        memReq.addr == $past(ptrVal) - 16'h0001 &&
        memReq.wdata == $past(rf_reg[inst.rr]))
        else $error("pre decrement store wrong");
    a_disp_addr: assert property (
        isMem && inst.op == fblse_pkg::displaced_load_op |=>
        memReq.addr == $past(ptrVal) + {10'h000, $past(inst.disp)} &&
        {rf_reg[$past(ptrLo) + 5'h01], rf_reg[$past(ptrLo)]} == $past(ptrVal))
        else $error("displaced load address wrong");
    a_direct_addr: assert property (
        isMem && inst.op == fblse_pkg::direct_load_op |=>
        memReq.read && memReq.addr == $past(inst.addr))
        else $error("direct load address wrong");
    a_two_cycle: assert property (
        isMem |=> !instReady && !instDone ##1 instReady && instDone &&
        flags_reg == $past(flags_reg, 2))
        else $error("memory transfer not two cycles or flags moved");
    a_one_cycle: assert property (
        accept && !isMem |=> instDone && instReady)
        else $error("single cycle op did not finish");
    a_load_data: assert property (
        state_reg == MEM_PHASE && pendLoad_reg |=>
        rf_reg[$past(pendDest_reg)] == $past(memRdata))
        else $error("load data not captured");

    c_bit_store: cover property (
        accept && inst.op == fblse_pkg::bit_to_transfer_flag_op);
    c_postinc_load: cover property (isMem && inst.mode ==
        fblse_pkg::PM_POST_INC ##2 instDone);
    c_store_back: cover property (isMem &&
        inst.op == fblse_pkg::displaced_store_op ##1 memReq.write);
endmodule : fblse_exec

/* File: testbench/fblse_mem_model.sv */
`timescale 1ns/10ps
// data memory on the far side, answers a read in the same cycle
module fblse_mem_model (
    input wire logic clock,
    input wire fblse_pkg::fblse_mem_t memReq,
    output logic [7:0] memRdata
);
    logic [7:0] mem [65536]; // whole data space
    logic [7:0] lastRd = 8'h00; // last byte handed out
    // preset contents to a pattern the bench can predict
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
        end
    end
    // outside a read the bus shows the inverse of the last byte
    assign memRdata = memReq.read ? mem[memReq.addr] : ~lastRd;
    // writes and read history land at the rising edge
    always @(posedge clock) begin
        if (memReq.write) begin
            mem[memReq.addr] <= memReq.wdata;
        end
        if (memReq.read) begin
            lastRd <= mem[memReq.addr];
        end
    end
endmodule : fblse_mem_model

/* File: testbench/test_fblse_exec.sv */
`timescale 1ns/10ps
module test_fblse_exec;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic instValid = 1'b0;
    fblse_pkg::fblse_inst_t inst = '0;
    logic instReady;
    logic instDone;
    fblse_pkg::fblse_mem_t memReq;
    logic [7:0] memRdata;
    logic [7:0] flags;
    logic [4:0] dbgSel = 5'h00;
    logic [7:0] dbgData;
    logic [7:0] rfm [32] = '{default: 8'h00}; // register file model
    logic [7:0] fm = 8'h00; // flag model
    logic [7:0] memExp [int]; // bytes stored so far
    logic [31:0] seed = 32'h0000002f; // xorshift state
    int fails = 0;
    int tests_run = 0;
    fblse_pkg::fblse_inst_t in;
    // free running clock
    always #2 clock = ~clock;
    fblse_exec fblse_exec_i (.clock(clock), .resetn(resetn),
        .instValid(instValid), .inst(inst), .instReady(instReady),
        .instDone(instDone), .memReq(memReq), .memRdata(memRdata),
        .flags(flags), .dbgSel(dbgSel), .dbgData(dbgData));
    fblse_mem_model fblse_mem_model_i (.clock(clock), .memReq(memReq),
        .memRdata(memRdata));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // random instruction, pointer and mode picked by k
    function automatic fblse_pkg::fblse_inst_t rnd(int o, int k);
        fblse_pkg::fblse_inst_t r;
        logic [31:0] t;
        t = xs();
        r.op = fblse_pkg::fblse_op_t'(o);
        r.rd = t[4:0];
        r.rr = t[9:5];
        r.bitSel = t[12:10];
        r.imm = t[20:13];
        r.disp = t[26:21];
        t = xs();
        r.addr = t[15:0];
        r.ptr = fblse_pkg::fblse_ptr_t'(k / 3);
        r.mode = fblse_pkg::fblse_mode_t'(k % 3);
        // bit store names one register, keep both fields equal
        if (r.op == fblse_pkg::bit_to_transfer_flag_op) begin
            r.rr = r.rd;
        end
        // displaced forms only through the upper pointers
        if (r.op == fblse_pkg::displaced_store_op || (r.ptr ==
            fblse_pkg::PTR_X && r.op == fblse_pkg::displaced_load_op)) begin
            r.ptr = fblse_pkg::PTR_Y;
        end
        return r;
    endfunction : rnd
    task automatic check(string w, logic [15:0] e, logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", w, e, s);
        end
    endtask : check
    // peek every register, one cycle each
    task automatic chkRegs();
        for (int i = 0; i < 32; i++) begin
            dbgSel = i[4:0];
            @(negedge clock);
            check($sformatf("r%0d", i), rfm[i], dbgData);
        end
    endtask : chkRegs
    // issue one instruction, update the model, compare every result
    task automatic run(fblse_pkg::fblse_inst_t n);
        logic [4:0] lo;
        logic [15:0] p;
        logic [15:0] a;
        logic [7:0] wd;
        logic isLoad;
        logic isStore;
        lo = n.ptr == fblse_pkg::PTR_X ? fblse_pkg::PTR_X_LO :
            n.ptr == fblse_pkg::PTR_Y ? fblse_pkg::PTR_Y_LO :
            fblse_pkg::PTR_Z_LO;
        p = {rfm[{lo[4:1], 1'b1}], rfm[lo]};
        wd = rfm[n.rr];
        isLoad = n.op inside {fblse_pkg::pointer_load_op,
            fblse_pkg::displaced_load_op, fblse_pkg::direct_load_op};
        isStore = n.op inside {fblse_pkg::pointer_store_op,
            fblse_pkg::displaced_store_op};
        a = p;
        case (n.op)
            fblse_pkg::flag_force_one_op: fm[n.bitSel] = 1'b1;
            fblse_pkg::flag_force_zero_op: fm[n.bitSel] = 1'b0;
            fblse_pkg::bit_to_transfer_flag_op:
                fm[fblse_pkg::FLAG_T] = rfm[n.rr][n.bitSel];
            fblse_pkg::transfer_flag_to_bit_op:
                rfm[n.rd][n.bitSel] = fm[fblse_pkg::FLAG_T];
            fblse_pkg::overflow_force_one_op: fm[3] = 1'b1;
            fblse_pkg::overflow_force_zero_op: fm[3] = 1'b0;
            fblse_pkg::half_carry_force_one_op: fm[5] = 1'b1;
            fblse_pkg::half_carry_force_zero_op: fm[5] = 1'b0;
            fblse_pkg::signed_test_force_one_op: fm[4] = 1'b1;
            fblse_pkg::signed_test_force_zero_op: fm[4] = 1'b0;
            fblse_pkg::move_op: rfm[n.rd] = rfm[n.rr];
            fblse_pkg::register_pair_copy_op: begin
                rfm[{n.rd[4:1], 1'b0}] = rfm[{n.rr[4:1], 1'b0}];
                rfm[{n.rd[4:1], 1'b1}] = rfm[{n.rr[4:1], 1'b1}];
            end
            fblse_pkg::immediate_load_op: rfm[n.rd] = n.imm;
            fblse_pkg::nibble_swap_op:
                rfm[n.rd] = {rfm[n.rd][3:0], rfm[n.rd][7:4]};
            fblse_pkg::displaced_load_op, fblse_pkg::displaced_store_op:
                a = p + {10'h000, n.disp};
            fblse_pkg::direct_load_op: a = n.addr;
            default: begin
                // pointer transfers step the pair unless plain
                if (n.mode == fblse_pkg::PM_PRE_DEC) begin
                    p = p - 16'h0001;
                    a = p;
                end else if (n.mode == fblse_pkg::PM_POST_INC) begin
                    p = p + 16'h0001;
                end
                if (isLoad || isStore) begin
                    {rfm[{lo[4:1], 1'b1}], rfm[lo]} = p;
                end
            end
        endcase
        @(negedge clock);
        inst = n;
        instValid = 1'b1;
        check("ready", 1, instReady);
        @(negedge clock);
        instValid = 1'b0;
        if (isLoad || isStore) begin
            check("read", isLoad, memReq.read);
            check("write", isStore, memReq.write);
            check("addr", a, memReq.addr);
            check("busy", 0, instReady);
            check("early done", 0, instDone);
            if (isStore) begin
                check("wdata", wd, memReq.wdata);
                memExp[a] = wd;
            end else begin
                rfm[n.rd] = memExp.exists(a) ? memExp[a] :
                    a[7:0] ^ a[15:8] ^ 8'h5a;
            end
            @(negedge clock);
        end else begin
            // single cycle ops must leave the memory bus quiet
            check("idle access", 0, {memReq.read, memReq.write});
        end
        check("done", 1, instDone);
        check("flags", fm, flags);
        chkRegs();
    endtask : run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////
    // watchdog, about four times the expected run
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        check("reset flags", 8'h00, flags);
        chkRegs();
        // every operation with every pointer and mode, displaced loads never through X, displaced stores only through Y
        for (int o = 0; o < 20; o++) begin
            for (int k = 0; k < 9; k++) begin
                run(rnd(o, k));
            end
        end
        // pointer wrap at both ends of the address space
        in = rnd(13, 0);
        in.imm = 8'h00;
        for (int r = 26; r < 28; r++) begin
            in.rd = r[4:0];
            run(in);
        end
        run(rnd(15, 2));
        in.imm = 8'hff;
        for (int r = 30; r < 32; r++) begin
            in.rd = r[4:0];
            run(in);
        end
        run(rnd(18, 7));
        // random mix
        repeat (150) begin
            run(rnd(int'(xs() % 20), int'(xs() % 9)));
        end
        print_verdict();
    end
endmodule : test_fblse_exec
